// ==== ebp_pkg.sv ====
// Constants, register map and carrier types of the eight-bit port.
// Assumes APB with 32-bit data; register index is byte address / 4.
package ebp_pkg;

  localparam int unsigned PORT_W   = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned IDX_W    = 10;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_DATA_A = 10'h006;
  localparam logic [9:0] IDX_DATA_B = 10'h106;
  localparam logic [9:0] IDX_DIR_A  = 10'h086;
  localparam logic [9:0] IDX_DIR_B  = 10'h186;
  localparam logic [9:0] IDX_OPT_A  = 10'h081;
  localparam logic [9:0] IDX_OPT_B  = 10'h181;
  localparam logic [9:0] IDX_STAT   = 10'h00b;
  localparam logic [9:0] IDX_MASK   = 10'h090;
  localparam logic [9:0] IDX_CTRL   = 10'h091;
  localparam logic [9:0] IDX_BSET   = 10'h092;
  localparam logic [9:0] IDX_BCLR   = 10'h093;

  // Reset values
  localparam logic [7:0] DIR_RST    = 8'hff;
  localparam logic [7:0] OPT_RST    = 8'hff;
  localparam logic       FLAG_RST   = 1'b0;
  localparam logic       MASK_RST   = 1'b0;
  localparam logic       LVP_RST    = 1'b0;

  // Field positions
  localparam int unsigned OPT_PULLUP_BIT = 7;
  localparam int unsigned STAT_CHG_BIT   = 0;
  localparam int unsigned CTRL_LVP_BIT   = 0;
  localparam int unsigned LVP_PIN        = 4;
  localparam int unsigned UPPER_LO       = 4;

  typedef enum logic [3:0] {
    EBP_SEL_NONE = 4'h0,
    EBP_SEL_DATA = 4'h1,
    EBP_SEL_DIR  = 4'h2,
    EBP_SEL_OPT  = 4'h3,
    EBP_SEL_STAT = 4'h4,
    EBP_SEL_MASK = 4'h5,
    EBP_SEL_CTRL = 4'h6,
    EBP_SEL_BSET = 4'h7,
    EBP_SEL_BCLR = 4'h8
  } ebp_sel_e;

  // Pin drive towards the pad ring
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
  } ebp_pad_s;

  typedef struct packed {
    logic [7:0]  pin_data_reg;
    logic [7:0]  direction_reg;
    logic [7:0]  option_reg;
    logic        lvp_en;
    logic        change_detect_flag;
    logic        change_mask;
    logic [7:0]  sample;
    logic [31:0] rdata;
  } ebp_state_s;

endpackage

// ==== ebp_sync2.sv ====
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous levels; no pulse capture.
`timescale 1ns/1ps
`default_nettype none
module ebp_sync2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ebp_sync_s;

  ebp_sync_s st_reg;
  ebp_sync_s st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < WIDTH; i++) begin
      st_next.s1[i] = async_in[i];
      st_next.s2[i] = st_reg.s1[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;
endmodule // ebp_sync2
`default_nettype wire

// ==== ebp_change_det.sv ====
// Change detector on the upper pins against the last port access.
// Assumes pins are already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
module ebp_change_det
  import ebp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] pins,
  input  wire logic [7:0] dir,
  input  wire logic       lvp_en,
  input  wire logic       reload,
  output logic            mismatch
);
  typedef struct packed {
    logic       valid;
    logic [7:0] snap;
  } ebp_det_s;

  ebp_det_s   st_reg;
  ebp_det_s   st_next;
  logic [7:0] diff;

  // Snapshot taken on the first cycle after reset avoids a false change
  always_comb begin
    st_next = st_reg;
    if (reload || !st_reg.valid) begin
      st_next.snap  = pins;
      st_next.valid = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_bit
      if (g < UPPER_LO) begin : g_low
        assign diff[g] = 1'b0;
      end else if (g == LVP_PIN) begin : g_lvp
        assign diff[g] = (pins[g] ^ st_reg.snap[g]) & dir[g] & ~lvp_en;
      end else begin : g_up
        assign diff[g] = (pins[g] ^ st_reg.snap[g]) & dir[g];
      end
    end
  endgenerate

  assign mismatch = st_reg.valid & (|diff);
endmodule // ebp_change_det
`default_nettype wire

// ==== ebp_port.sv ====
// Eight-bit bidirectional port with APB register access.
// Assumes pin inputs are asynchronous and the pad ring resolves
// out, oe and pullup_en into the real pin level.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Eight bidirectional pins, each with a software-enabled weak pull-up.
// - Pin four gates off change detect and pull-up when low-voltage programming on.
// - Upper pins join change detection and have selectable pull-ups.
// - Reading port data returns pin levels, not the output latch.
// - Writing port data loads the output latch driving output pins.
// - Bit set and clear read all pins, modify, write whole latch.
// - Input pins get their sampled level copied into the latch.
// - Writes land at end of access; reads sample at its start.
// - Port data at two mirrors, bit n is pin n, reset leaves it.
// - Direction at two mirrors, one bit per pin, resets to all ones.
// - Option at two mirrors, pull-up control in bit 7, resets all ones.
// - Upper input pins compared with last port access snapshot set the change flag.
// - Port data access ends the mismatch; a standing mismatch keeps setting.
module ebp_port
  import ebp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        pin_in,
  output ebp_pad_s               pad,
  output logic                   irq
);
  import ebp_pkg::*;

  ebp_state_s st_reg;
  ebp_state_s st_next;
  logic [7:0] pins_sync;
  logic       mismatch;
  logic       reload;
  logic       setup_ph;
  logic       access_ph;
  logic       wr_acc;
  logic       flag_clr;
  ebp_sel_e   sel;
  logic [7:0] rd_val;
  logic [7:0] pull_ok;

  // Pin levels cross into pclk before anything looks at them
  ebp_sync2 #(
    .WIDTH (PORT_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pins_sync)
  );

  ebp_change_det u_det (
    .pclk     (pclk),
    .presetn  (presetn),
    .pins     (pins_sync),
    .dir      (st_reg.direction_reg),
    .lvp_en   (st_reg.lvp_en),
    .reload   (reload),
    .mismatch (mismatch)
  );

  function automatic ebp_sel_e decode(input logic [IDX_W-1:0] idx);
    ebp_sel_e s;
    s = EBP_SEL_NONE;
    case (idx)
      IDX_DATA_A,
      IDX_DATA_B: begin
        s = EBP_SEL_DATA;
      end
      IDX_DIR_A,
      IDX_DIR_B: begin
        s = EBP_SEL_DIR;
      end
      IDX_OPT_A,
      IDX_OPT_B: begin
        s = EBP_SEL_OPT;
      end
      IDX_STAT: begin
        s = EBP_SEL_STAT;
      end
      IDX_MASK: begin
        s = EBP_SEL_MASK;
      end
      IDX_CTRL: begin
        s = EBP_SEL_CTRL;
      end
      IDX_BSET: begin
        s = EBP_SEL_BSET;
      end
      IDX_BCLR: begin
        s = EBP_SEL_BCLR;
      end
      default: begin
        s = EBP_SEL_NONE;
      end
    endcase
    return s;
  endfunction

  assign sel       = decode(paddr[ADDR_W-1:2]);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite;

  // Read mux; the port windows show the pins, never the latch
  always_comb begin
    rd_val = 8'h00;
    case (sel)
      EBP_SEL_DATA,
      EBP_SEL_BSET,
      EBP_SEL_BCLR: begin
        rd_val = pins_sync;
      end
      EBP_SEL_DIR: begin
        rd_val = st_reg.direction_reg;
      end
      EBP_SEL_OPT: begin
        rd_val = st_reg.option_reg;
      end
      EBP_SEL_STAT: begin
        rd_val = 8'h00;
        rd_val[STAT_CHG_BIT] = st_reg.change_detect_flag;
      end
      EBP_SEL_MASK: begin
        rd_val = 8'h00;
        rd_val[STAT_CHG_BIT] = st_reg.change_mask;
      end
      EBP_SEL_CTRL: begin
        rd_val = 8'h00;
        rd_val[CTRL_LVP_BIT] = st_reg.lvp_en;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // Any access to a port window restarts change comparison
  assign reload = access_ph & ((sel == EBP_SEL_DATA) |
                               (sel == EBP_SEL_BSET) |
                               (sel == EBP_SEL_BCLR));

  assign flag_clr = wr_acc & (sel == EBP_SEL_STAT) & pwdata[STAT_CHG_BIT];

  always_comb begin
    st_next = st_reg;

    // Pins are sampled in the setup cycle, the start of the access
    if (setup_ph) begin
      st_next.sample = pins_sync;
      st_next.rdata  = {24'h000000, rd_val};
    end

    // Writes commit at the closing edge of the access phase
    if (wr_acc) begin
      case (sel)
        EBP_SEL_DATA: begin
          st_next.pin_data_reg = pwdata[7:0];
        end
        EBP_SEL_BSET: begin
          // Whole latch rewritten from pins: inputs get their pin level
          st_next.pin_data_reg = st_reg.sample | pwdata[7:0];
        end
        EBP_SEL_BCLR: begin
          st_next.pin_data_reg = st_reg.sample & ~pwdata[7:0];
        end
        EBP_SEL_DIR: begin
          st_next.direction_reg = pwdata[7:0];
        end
        EBP_SEL_OPT: begin
          st_next.option_reg = pwdata[7:0];
        end
        EBP_SEL_MASK: begin
          st_next.change_mask = pwdata[STAT_CHG_BIT];
        end
        EBP_SEL_CTRL: begin
          st_next.lvp_en = pwdata[CTRL_LVP_BIT];
        end
        default: begin
          st_next.pin_data_reg = st_reg.pin_data_reg;
        end
      endcase
    end

    // Set beats clear so a change in the clearing cycle survives
    if (flag_clr) begin
      st_next.change_detect_flag = 1'b0;
    end
    if (mismatch) begin
      st_next.change_detect_flag = 1'b1;
    end
  end

  // The output latch is left out of reset on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.direction_reg      <= DIR_RST;
      st_reg.option_reg         <= OPT_RST;
      st_reg.lvp_en             <= LVP_RST;
      st_reg.change_detect_flag <= FLAG_RST;
      st_reg.change_mask        <= MASK_RST;
      st_reg.sample             <= 8'h00;
      st_reg.rdata              <= 32'h00000000;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pull-up qualifier per pin; pin four also yields to programming mode
  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_pull
      if (g == LVP_PIN) begin : g_lvp
        assign pull_ok[g] = ~st_reg.lvp_en;
      end else begin : g_std
        assign pull_ok[g] = 1'b1;
      end
    end
  endgenerate

  // Unknown latch after power-up is masked while every pin is input
  assign pad.oe  = ~st_reg.direction_reg;
  assign pad.out = st_reg.pin_data_reg & ~st_reg.direction_reg;
  assign pad.pullup_en = {PORT_W{~st_reg.option_reg[OPT_PULLUP_BIT]}} &
                         st_reg.direction_reg & pull_ok;

  assign prdata  = st_reg.rdata;
  assign pready  = 1'b1;
  assign pslverr = access_ph & (sel == EBP_SEL_NONE);
  assign irq     = st_reg.change_detect_flag & st_reg.change_mask;

endmodule // ebp_port
`default_nettype wire

// ==== ebp_port_properties.sv ====
// Concurrent checks on the port's APB and pad outputs.
// Assumes it is bound onto ebp_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ebp_port_properties (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [ebp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [7:0]                pin_in,
  input wire ebp_pkg::ebp_pad_s         pad,
  input wire logic                      irq
);
  import ebp_pkg::*;
  logic [9:0] idx;
  logic       wr;
  assign idx = paddr[11:2];
  assign wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dir_drive: assert property (
    wr && (idx == IDX_DIR_A || idx == IDX_DIR_B) |=> pad.oe == ~$past(pwdata[7:0]))
    else $error("oe not from direction");
  a_latch_out: assert property (
    wr && (idx == IDX_DATA_A || idx == IDX_DATA_B) |=> pad.out == ($past(pwdata[7:0]) & pad.oe))
    else $error("out not from latch");
  a_idle_low: assert property ((pad.out & ~pad.oe) == 8'h00)
    else $error("out set on input pin");
  a_pu_input: assert property ((pad.pullup_en & pad.oe) == 8'h00)
    else $error("pull-up on output pin");
  a_pu_off: assert property (
    wr && (idx == IDX_OPT_A || idx == IDX_OPT_B) && pwdata[7] |=> pad.pullup_en == 8'h00)
    else $error("pull-up not disabled");
  a_pu_upper: assert property (
    wr && (idx == IDX_OPT_A || idx == IDX_OPT_B) && !pwdata[7] |=> pad.pullup_en[7:5] == ~pad.oe[7:5])
    else $error("upper pull-up wrong");
  a_lvp_gate: assert property (
    wr && idx == IDX_CTRL && pwdata[0] |=> !pad.pullup_en[4])
    else $error("pin four pull-up on");
  a_read_pins: assert property (
    $stable(pin_in)[*4] ##0 (psel && !penable && !pwrite && idx == IDX_DATA_A)
    |=> prdata[7:0] == $past(pin_in)) else $error("read not pin level");
  a_irq_sticky: assert property (
    irq && !(psel && (idx == IDX_STAT || idx == IDX_MASK)) |=> irq)
    else $error("irq dropped alone");
endmodule // ebp_port_properties
bind ebp_port ebp_port_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pad, .irq);
`default_nettype wire

// ==== ebp_board.sv ====
// Board model: resolves pad drive, pull-ups and outside drivers.
// Assumes ebp_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
module ebp_board (
  input  wire logic              pclk,
  input  wire ebp_pkg::ebp_pad_s pad,
  input  wire logic [7:0]        ext_en,
  input  wire logic [7:0]        ext_val,
  output var  logic [7:0]        pin_in
);
  import ebp_pkg::*;
  // Undriven pins wander, so a missing pull-up cannot pass by luck
  logic [7:0] flt_reg = 8'h55;
  always @(posedge pclk) begin
    flt_reg <= ~flt_reg;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pad.oe[i] ? pad.out[i] : ext_en[i] ? ext_val[i] : pad.pullup_en[i] | flt_reg[i];
    end
  end
endmodule // ebp_board
`default_nettype wire

// ==== ebp_tb.sv ====
// Self-checking bench for the eight-bit port with a board model.
// Assumes ebp_pkg, ebp_port, the checker and ebp_board compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ebp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, last_err;
  logic [7:0]  pin_in;
  logic [7:0]  ext_en = 8'hff;
  logic [7:0]  ext_val = 8'h00;
  ebp_pad_s    pad;
  int          n_fail = 0;
  int          compares = 0;
  always #4 pclk = ~pclk;
  ebp_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_in, .pad, .irq);
  ebp_board u_board (.pclk, .pad, .ext_en, .ext_val, .pin_in);
  task automatic summarize();
    $display("Counts: %0d compares, %0d failed", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, i, d, r);
    #1;
  endtask
  task automatic rd(input string nm, input logic [9:0] i, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, i, 8'h00, r);
    chk(nm, exp, r);
  endtask
  // Pins pass a two-flop synchroniser before any read sees them
  task automatic gap();
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_reset(input logic [7:0] latch);
    rd("dir", IDX_DIR_A, 32'h000000ff);
    rd("opt", IDX_OPT_B, 32'h000000ff);
    chk("pullup", 32'h00000000, pad.pullup_en);
    rd("unmapped", 10'h3ff, 32'h00000000);
    chk("slverr", 32'h00000001, last_err);
    wr(IDX_DIR_B, 8'h00);
    chk("kept latch", latch, pad.out);
    wr(IDX_DIR_B, 8'hff);
    $display("t_reset done");
  endtask
  task automatic t_io_rmw();
    ext_val <= 8'ha0;
    wr(IDX_DIR_B, 8'hf0);
    wr(IDX_DATA_B, 8'h5a);
    chk("out", 32'h0000000a, pad.out);
    gap();
    rd("pins", IDX_DATA_A, 32'h000000aa);
    ext_val <= 8'hc0;
    gap();
    wr(IDX_BSET, 8'h01);
    wr(IDX_DIR_A, 8'h00);
    chk("rmw set", 32'h000000cb, pad.out);
    gap();
    wr(IDX_BCLR, 8'h81);
    chk("rmw clr", 32'h0000004a, pad.out);
    $display("t_io_rmw done");
  endtask
  task automatic t_pullup();
    wr(IDX_DIR_A, 8'hff);
    wr(IDX_OPT_A, 8'h7f);
    ext_en <= 8'h00;
    chk("pullup", 32'h000000ff, pad.pullup_en);
    gap();
    rd("pulled", IDX_DATA_B, 32'h000000ff);
    wr(IDX_CTRL, 8'h01);
    chk("pullup lvp", 32'h000000ef, pad.pullup_en);
    ext_en <= 8'hff;
    wr(IDX_OPT_B, 8'hff);
    $display("t_pullup done");
  endtask
  task automatic t_change();
    int n;
    wr(IDX_CTRL, 8'h00);
    wr(IDX_MASK, 8'h01);
    rd("snap", IDX_DATA_A, 32'h000000c0);
    wr(IDX_STAT, 8'h01);
    chk("irq idle", 32'h00000000, irq);
    ext_val <= 8'h80;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("irq raise", 32'h00000001, irq);
    wr(IDX_STAT, 8'h01);
    chk("irq held", 32'h00000001, irq);
    rd("pins", IDX_DATA_A, 32'h00000080);
    wr(IDX_STAT, 8'h01);
    chk("irq clear", 32'h00000000, irq);
    wr(IDX_CTRL, 8'h01);
    ext_val <= 8'h90;
    repeat (10) @(posedge pclk);
    rd("lvp flag", IDX_STAT, 32'h00000000);
    wr(IDX_MASK, 8'h00);
    ext_val <= 8'hd0;
    repeat (10) @(posedge pclk);
    chk("masked", 32'h00000000, irq);
    rd("flag", IDX_STAT, 32'h00000001);
    wr(IDX_MASK, 8'h01);
    chk("unmasked", 32'h00000001, irq);
    $display("t_change done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wr(IDX_DATA_A, 8'h3c);
    t_io_rmw();
    t_pullup();
    t_change();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset(8'h4a);
    summarize();
  end
endmodule // tb
`default_nettype wire
